// ==== fpc_defs.vh ====
`ifndef FPC_DEFS_VH
`define FPC_DEFS_VH

// APB register byte offsets
`define FPC_OFF_STATUS 12'h000
`define FPC_OFF_SET 12'h004
`define FPC_OFF_CLR 12'h008
`define FPC_OFF_BATT 12'h00c
`define FPC_OFF_CHGCNT 12'h010

// Function bit positions
`define FPC_F_GND_INH 0
`define FPC_F_ONE_SHOT 1
`define FPC_F_REM_LOCK 2
`define FPC_F_INRUSH_INH 3
`define FPC_F_BATT_TEST 4
`define FPC_F_SLOW_ONLY 5
`define FPC_F_ALT1 6
`define FPC_F_ALT3 8
`define FPC_NFUNC 9

// Status register fields
`define FPC_ST_TAG 9
`define FPC_ST_TAG_SUP 10
`define FPC_ST_BATT_FAULT 11
`define FPC_ST_CHG_MODE 12
`define FPC_ST_PSAVE 13

// Reset values
`define FPC_FUNC_RST 9'h000

// Supervisory link index that addresses the live-work tag
`define FPC_SUP_TAG_IDX 4'h9

// Timing
`define FPC_CLK_MHZ 200
`define FPC_CHG_WIN_S 10
`define FPC_DRAIN_MS 200
`define FPC_SETTLE_MS 500
`define FPC_LOAD_MS 1000

// Battery thresholds in millivolts
`define FPC_DROP_MAX_MV 16'h07d0
`define FPC_LOW_MV 16'h55f0

// Trip curve selection codes
`define FPC_CRV_NORMAL 3'h0
`define FPC_CRV_FIRST 3'h1
`define FPC_CRV_SLOW 3'h2
`define FPC_CRV_TAG 3'h3
`define FPC_CRV_INRUSH 3'h4

`endif

// ==== fpc_batt_seq.v ====
`timescale 1ns/10ps
`default_nettype none
`include "fpc_defs.vh"

module fpc_batt_seq #(
  parameter DRAIN_CYC = 32'd40000000,
  parameter SETTLE_CYC = 32'd100000000,
  parameter LOAD_CYC = 32'd200000000
) (
  input wire clk,
  input wire rstN,
  input wire start,
  input wire [15:0] voltMv,
  output reg busy,
  output reg drainOn,
  output reg loadOn,
  output reg done,
  output reg fail,
  output reg [15:0] settledMv,
  output reg [15:0] loadedMv
);
  localparam IDLE = 2'h0;
  localparam DRAIN = 2'h1;
  localparam SETTLE = 2'h2;
  localparam LOAD = 2'h3;

  reg [1:0] state_r;
  reg [31:0] cnt_r;
  wire cntEnd;
  wire [15:0] drop;

  assign cntEnd = (cnt_r == 32'h0);
  assign drop = settledMv - voltMv;

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_r <= IDLE;
      cnt_r <= 32'h0;
      busy <= 1'b0;
      drainOn <= 1'b0;
      loadOn <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      settledMv <= 16'h0;
      loadedMv <= 16'h0;
    end else begin
      done <= 1'b0;
      if (!cntEnd) begin
        cnt_r <= cnt_r - 32'h1;
      end
      case (state_r)
        IDLE: begin
          if (start) begin
            state_r <= DRAIN;
            cnt_r <= DRAIN_CYC - 32'h1;
            busy <= 1'b1;
            drainOn <= 1'b1;
          end
        end
        DRAIN: begin
          if (cntEnd) begin
            state_r <= SETTLE;
            cnt_r <= SETTLE_CYC - 32'h1;
            drainOn <= 1'b0;
          end
        end
        SETTLE: begin
          if (cntEnd) begin
            state_r <= LOAD;
            cnt_r <= LOAD_CYC - 32'h1;
            settledMv <= voltMv;
            loadOn <= 1'b1;
          end
        end
        LOAD: begin
          if (cntEnd) begin
            state_r <= IDLE;
            loadOn <= 1'b0;
            busy <= 1'b0;
            done <= 1'b1;
            loadedMv <= voltMv;
            fail <= (settledMv > voltMv) && (drop > `FPC_DROP_MAX_MV);
          end
        end
        default: begin
          state_r <= IDLE;
        end
      endcase
    end
  end
endmodule

`default_nettype wire

// ==== fpc_front_panel.v ====
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "fpc_defs.vh"

module fpc_front_panel #(
  parameter CHG_WIN_CYC = `FPC_CHG_WIN_S * `FPC_CLK_MHZ * 1000000,
  parameter DRAIN_CYC = `FPC_DRAIN_MS * `FPC_CLK_MHZ * 1000,
  parameter SETTLE_CYC = `FPC_SETTLE_MS * `FPC_CLK_MHZ * 1000,
  parameter LOAD_CYC = `FPC_LOAD_MS * `FPC_CLK_MHZ * 1000
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire [8:0] funcKeyPin,
  input wire changeKeyPin,
  input wire tagSwitchPin,
  input wire tripKeyPin,
  input wire closeKeyPin,
  input wire [8:0] discSetPin,
  input wire [8:0] discClrPin,
  input wire powerSave,
  input wire supCmdValid,
  input wire supCmdSet,
  input wire [3:0] supCmdIdx,
  input wire [15:0] battVoltMv,
  input wire remoteCloseReq,
  input wire autoCloseReq,
  output reg [8:0] funcLamp,
  output reg tagLamp,
  output reg battFaultLamp,
  output reg chgModeLamp,
  output reg gndTripInhibit,
  output reg reclosingBlocked,
  output reg oneTripLockout,
  output reg [2:0] curveSel,
  output reg [1:0] profileSel,
  output reg useInrush,
  output reg tripCmd,
  output reg closeCmd,
  output wire battDrainOn,
  output wire battLoadOn
);
  localparam NPIN = 31;
  localparam [31:0] WIN_CYC = CHG_WIN_CYC;

  // Reset release
  reg [1:0] rstPipe_r;
  wire rstN;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_r <= 2'h0;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end
  assign rstN = rstPipe_r[1];

  // Pin synchronisers and edge detection
  wire [NPIN-1:0] pinRaw;
  reg [NPIN-1:0] pinS1_r;
  reg [NPIN-1:0] pinS2_r;
  reg [NPIN-1:0] pinS3_r;
  wire [NPIN-1:0] pinRise;
  wire [NPIN-1:0] pinFall;
  assign pinRaw = {discClrPin, discSetPin, closeKeyPin, tripKeyPin, tagSwitchPin, changeKeyPin, funcKeyPin};

  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : gSync
      always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          pinS1_r[g] <= 1'b0;
          pinS2_r[g] <= 1'b0;
          pinS3_r[g] <= 1'b0;
        end else begin
          pinS1_r[g] <= pinRaw[g];
          pinS2_r[g] <= pinS1_r[g];
          pinS3_r[g] <= pinS2_r[g];
        end
      end
      assign pinRise[g] = pinS2_r[g] & ~pinS3_r[g];
      assign pinFall[g] = ~pinS2_r[g] & pinS3_r[g];
    end
  endgenerate

  wire [8:0] keyPress;
  wire changePress;
  wire tagUp;
  wire tagDown;
  wire tripPress;
  wire closePress;
  wire [8:0] discSet;
  wire [8:0] discClr;
  assign keyPress = pinRise[8:0];
  assign changePress = pinRise[9];
  assign tagUp = pinRise[10];
  assign tagDown = pinFall[10];
  assign tripPress = pinRise[11];
  assign closePress = pinRise[12];
  assign discSet = pinRise[21:13];
  assign discClr = pinRise[30:22];

  // State
  reg [8:0] func_r;
  reg chgMode_r;
  reg [31:0] chgCnt_r;
  reg tagOn_r;
  reg tagSup_r;
  reg battFault_r;
  wire remLock;
  wire battBusy;
  wire battDone;
  wire battFail;
  wire [15:0] settledMv;
  wire [15:0] loadedMv;
  assign remLock = func_r[`FPC_F_REM_LOCK];

  // Local selection: lowest key pressed inside the change window
  reg [8:0] localPick;
  integer i;
  always @* begin
    localPick = 9'h000;
    for (i = `FPC_NFUNC - 1; i >= 0; i = i - 1) begin
      if (keyPress[i]) begin
        localPick = 9'h000;
        localPick[i] = 1'b1;
      end
    end
    if (!chgMode_r) begin
      localPick = 9'h000;
    end
  end

  // APB decode
  wire apbWr;
  wire apbRd;
  wire hitSet;
  wire hitClr;
  wire mapped;
  assign apbWr = psel & penable & pwrite;
  assign apbRd = psel & ~pwrite;
  assign hitSet = apbWr && (paddr == `FPC_OFF_SET);
  assign hitClr = apbWr && (paddr == `FPC_OFF_CLR);
  assign mapped = (paddr == `FPC_OFF_STATUS) || (paddr == `FPC_OFF_SET) || (paddr == `FPC_OFF_CLR)
    || (paddr == `FPC_OFF_BATT) || (paddr == `FPC_OFF_CHGCNT);
  assign pready = 1'b1;

  // Remote requests; link and software drop out under remote lockout
  wire [8:0] supSet;
  wire [8:0] supClr;
  wire supOk;
  wire [8:0] pcSet;
  wire [8:0] pcClr;
  wire [8:0] remSet;
  wire [8:0] remClr;
  wire [8:0] lockMask;
  assign supOk = supCmdValid & ~remLock & (supCmdIdx < 4'h9);
  assign supSet = (supOk & supCmdSet) ? (9'h001 << supCmdIdx) : 9'h000;
  assign supClr = (supOk & ~supCmdSet) ? (9'h001 << supCmdIdx) : 9'h000;
  assign pcSet = (hitSet & ~remLock) ? pwdata[8:0] : 9'h000;
  assign pcClr = (hitClr & ~remLock) ? pwdata[8:0] : 9'h000;
  assign lockMask = ~(9'h001 << `FPC_F_REM_LOCK);
  assign remSet = (supSet | pcSet | discSet) & lockMask;
  assign remClr = (supClr | pcClr | discClr) & lockMask;

  // Combined set/clear; a local key other than the battery test key toggles its function
  wire [8:0] setReq;
  wire [8:0] clrReq;
  assign setReq = remSet | (localPick & ~func_r);
  assign clrReq = remClr | (localPick & func_r);

  wire battStart;
  assign battStart = setReq[`FPC_F_BATT_TEST] & ~battBusy;

  reg [8:0] func_nxt;
  reg [2:0] altPick;
  always @* begin
    func_nxt = (func_r & ~clrReq) | setReq;
    func_nxt[`FPC_F_BATT_TEST] = 1'b0;
    altPick = 3'h0;
    if (setReq[`FPC_F_ALT1]) begin
      altPick = 3'h1;
    end else if (setReq[`FPC_F_ALT1 + 1]) begin
      altPick = 3'h2;
    end else if (setReq[`FPC_F_ALT3]) begin
      altPick = 3'h4;
    end
    if (altPick != 3'h0) begin
      func_nxt[`FPC_F_ALT3:`FPC_F_ALT1] = altPick;
    end else begin
      func_nxt[`FPC_F_ALT3:`FPC_F_ALT1] = func_r[`FPC_F_ALT3:`FPC_F_ALT1] & ~clrReq[`FPC_F_ALT3:`FPC_F_ALT1];
    end
  end

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      func_r <= `FPC_FUNC_RST;
    end else begin
      func_r <= func_nxt;
    end
  end

  // Change mode window
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      chgMode_r <= 1'b0;
      chgCnt_r <= 32'h0;
    end else if (changePress) begin
      chgMode_r <= 1'b1;
      chgCnt_r <= WIN_CYC - 32'h1;
    end else if (chgMode_r) begin
      if (localPick != 9'h000) begin
        chgMode_r <= 1'b0;
      end else if (chgCnt_r == 32'h0) begin
        chgMode_r <= 1'b0;
      end else begin
        chgCnt_r <= chgCnt_r - 32'h1;
      end
    end
  end

  // Live-work tag with source ownership
  wire supTagSet;
  wire supTagClr;
  assign supTagSet = supCmdValid & ~remLock & supCmdSet & (supCmdIdx == `FPC_SUP_TAG_IDX);
  assign supTagClr = supCmdValid & ~remLock & ~supCmdSet & (supCmdIdx == `FPC_SUP_TAG_IDX);
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      tagOn_r <= 1'b0;
      tagSup_r <= 1'b0;
    end else if (!tagOn_r) begin
      if (tagUp) begin
        tagOn_r <= 1'b1;
        tagSup_r <= 1'b0;
      end else if (supTagSet) begin
        tagOn_r <= 1'b1;
        tagSup_r <= 1'b1;
      end
    end else if (tagSup_r ? supTagClr : tagDown) begin
      tagOn_r <= 1'b0;
      tagSup_r <= 1'b0;
    end
  end

  // Battery fault flag; setting wins over the clearing test result
  wire lowVolt;
  assign lowVolt = battVoltMv < `FPC_LOW_MV;
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      battFault_r <= 1'b0;
    end else if ((battDone & battFail) | lowVolt) begin
      battFault_r <= 1'b1;
    end else if (battDone) begin
      battFault_r <= 1'b0;
    end
  end

  fpc_batt_seq #(
    .DRAIN_CYC(DRAIN_CYC),
    .SETTLE_CYC(SETTLE_CYC),
    .LOAD_CYC(LOAD_CYC)
  ) uBatt (
    .clk(clk),
    .rstN(rstN),
    .start(battStart),
    .voltMv(battVoltMv),
    .busy(battBusy),
    .drainOn(battDrainOn),
    .loadOn(battLoadOn),
    .done(battDone),
    .fail(battFail),
    .settledMv(settledMv),
    .loadedMv(loadedMv)
  );

  // Protection controls and lamps
  wire [8:0] funcView;
  reg [2:0] curve_nxt;
  reg [1:0] prof_nxt;
  assign funcView = {func_r[8:5], battBusy, func_r[3:0]};
  always @* begin
    if (tagOn_r) begin
      curve_nxt = `FPC_CRV_TAG;
    end else if (func_r[`FPC_F_SLOW_ONLY]) begin
      curve_nxt = `FPC_CRV_SLOW;
    end else if (func_r[`FPC_F_ONE_SHOT]) begin
      curve_nxt = `FPC_CRV_FIRST;
    end else if (!func_r[`FPC_F_INRUSH_INH]) begin
      curve_nxt = `FPC_CRV_INRUSH;
    end else begin
      curve_nxt = `FPC_CRV_NORMAL;
    end
    prof_nxt = 2'h0;
    if (func_r[`FPC_F_ALT1]) begin
      prof_nxt = 2'h1;
    end else if (func_r[`FPC_F_ALT1 + 1]) begin
      prof_nxt = 2'h2;
    end else if (func_r[`FPC_F_ALT3]) begin
      prof_nxt = 2'h3;
    end
  end

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      funcLamp <= 9'h000;
      tagLamp <= 1'b0;
      battFaultLamp <= 1'b0;
      chgModeLamp <= 1'b0;
      gndTripInhibit <= 1'b0;
      reclosingBlocked <= 1'b0;
      oneTripLockout <= 1'b0;
      curveSel <= `FPC_CRV_NORMAL;
      profileSel <= 2'h0;
      useInrush <= 1'b0;
      tripCmd <= 1'b0;
      closeCmd <= 1'b0;
    end else begin
      funcLamp <= powerSave ? 9'h000 : funcView;
      tagLamp <= tagOn_r;
      battFaultLamp <= battFault_r;
      chgModeLamp <= chgMode_r;
      gndTripInhibit <= func_r[`FPC_F_GND_INH];
      reclosingBlocked <= func_r[`FPC_F_ONE_SHOT] | tagOn_r;
      oneTripLockout <= func_r[`FPC_F_ONE_SHOT] | tagOn_r;
      curveSel <= curve_nxt;
      profileSel <= prof_nxt;
      useInrush <= ~func_r[`FPC_F_INRUSH_INH] & ~tagOn_r;
      tripCmd <= tripPress;
      closeCmd <= (closePress | remoteCloseReq | (autoCloseReq & ~func_r[`FPC_F_ONE_SHOT])) & ~tagOn_r;
    end
  end

  // APB read data, registered at the setup cycle
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel & ~penable & ~mapped;
      prdata <= 32'h0;
      if (apbRd & ~penable) begin
        case (paddr)
          `FPC_OFF_STATUS: begin
            prdata <= {18'h0, powerSave, chgMode_r, battFault_r, tagSup_r, tagOn_r, funcView};
          end
          `FPC_OFF_BATT: begin
            prdata <= {loadedMv, settledMv};
          end
          `FPC_OFF_CHGCNT: begin
            prdata <= chgCnt_r;
          end
          default: begin
            prdata <= 32'h0;
          end
        endcase
      end else if (psel & penable) begin
        prdata <= prdata;
      end
    end
  end
endmodule

`default_nettype wire

// ==== fpc_front_panel_props.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fpc_defs.vh"
module fpc_front_panel_props (
  input wire clk,
  input wire rst_n,
  input wire powerSave,
  input wire [15:0] battVoltMv,
  input wire [8:0] funcLamp,
  input wire tagLamp,
  input wire battFaultLamp,
  input wire chgModeLamp,
  input wire oneTripLockout,
  input wire [2:0] curveSel,
  input wire tripCmd,
  input wire closeCmd,
  input wire battDrainOn,
  input wire battLoadOn
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_dark;
    powerSave [*2] |-> funcLamp == 9'h000;
  endproperty
  a_dark: assert property (p_dark) else $error("lamps lit in power save");
  property p_lock;
    $changed(funcLamp[2]) && !$past(powerSave) && !$past(powerSave, 2) && !$past(powerSave, 3)
      |-> $past(chgModeLamp) || $past(chgModeLamp, 2);
  endproperty
  a_lock: assert property (p_lock) else $error("lockout changed outside change mode");
  property p_noClose;
    tagLamp [*2] |-> !closeCmd;
  endproperty
  a_noClose: assert property (p_noClose) else $error("close while tagged");
  property p_noTrip;
    $rose(tagLamp) |-> !tripCmd;
  endproperty
  a_noTrip: assert property (p_noTrip) else $error("trip on tag");
  property p_tagProt;
    tagLamp [*2] |-> oneTripLockout && curveSel == `FPC_CRV_TAG;
  endproperty
  a_tagProt: assert property (p_tagProt) else $error("tag protection wrong");
  property p_battLamp;
    battLoadOn && !powerSave |-> ##1 funcLamp[4];
  endproperty
  a_battLamp: assert property (p_battLamp) else $error("test lamp dark");
  property p_order;
    $rose(battLoadOn) |-> !battDrainOn && !$past(battDrainOn, 4);
  endproperty
  a_order: assert property (p_order) else $error("load without settle");
  property p_oneAlt;
    !powerSave |-> $onehot0(funcLamp[8:6]);
  endproperty
  a_oneAlt: assert property (p_oneAlt) else $error("two alternates");
  property p_low;
    battVoltMv < `FPC_LOW_MV |-> ##[1:3] battFaultLamp;
  endproperty
  a_low: assert property (p_low) else $error("low battery missed");
endmodule
bind fpc_front_panel fpc_front_panel_props u_props (.clk(clk), .rst_n(rst_n), .powerSave(powerSave),
  .battVoltMv(battVoltMv), .funcLamp(funcLamp), .tagLamp(tagLamp), .battFaultLamp(battFaultLamp),
  .chgModeLamp(chgModeLamp), .oneTripLockout(oneTripLockout), .curveSel(curveSel), .tripCmd(tripCmd),
  .closeCmd(closeCmd), .battDrainOn(battDrainOn), .battLoadOn(battLoadOn));
`default_nettype wire

// ==== fpc_panel_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module fpc_panel_model (
  input wire clk,
  output logic [8:0] funcKeyPin,
  output logic changeKeyPin,
  output logic tagSwitchPin,
  output logic supCmdValid,
  output logic supCmdSet,
  output logic [3:0] supCmdIdx
);
  initial begin
    funcKeyPin = 9'h000;
    changeKeyPin = 1'b0;
    tagSwitchPin = 1'b0;
    supCmdValid = 1'b0;
    supCmdSet = 1'b0;
    supCmdIdx = 4'h0;
  end
  // Press index 9 is the change key; held past the synchroniser
  task automatic hold(input integer i);
    @(posedge clk);
    if (i > 8) changeKeyPin <= 1'b1;
    else funcKeyPin[i] <= 1'b1;
    repeat (4) @(posedge clk);
    changeKeyPin <= 1'b0;
    funcKeyPin <= 9'h000;
    repeat (4) @(posedge clk);
  endtask
  task automatic keySeq(input integer i);
    hold(9);
    hold(i);
  endtask
  // Idle link lines show garbage once valid drops
  task automatic sup(input logic s, input logic [3:0] i);
    @(posedge clk);
    supCmdValid <= 1'b1;
    supCmdSet <= s;
    supCmdIdx <= i;
    @(posedge clk);
    supCmdValid <= 1'b0;
    supCmdSet <= ~s;
    supCmdIdx <= ~i;
    repeat (3) @(posedge clk);
  endtask
  task automatic tag(input logic v);
    @(posedge clk);
    tagSwitchPin <= v;
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== fpc_front_panel_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fpc_defs.vh"
module fpc_front_panel_test;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, tripKeyPin, closeKeyPin, powerSave;
  logic remoteCloseReq, autoCloseReq, tagLamp, battFaultLamp, chgModeLamp, gndTripInhibit, reclosingBlocked;
  logic oneTripLockout, useInrush, tripCmd, closeCmd, battDrainOn, battLoadOn, changeKeyPin, tagSwitchPin;
  logic supCmdValid, supCmdSet, errQ, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, prdQ, rd;
  logic [8:0] funcKeyPin, discSetPin, discClrPin, funcLamp;
  logic [3:0] supCmdIdx;
  logic [15:0] battVoltMv;
  logic [2:0] curveSel;
  logic [1:0] profileSel;
  integer nMismatch = 0, samplesChecked = 0, nTrip, nClose;
  fpc_front_panel #(.CHG_WIN_CYC(50), .DRAIN_CYC(8), .SETTLE_CYC(8), .LOAD_CYC(8)) dut (.*);
  fpc_panel_model ops (.*);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    prdQ <= prdata;
    errQ <= pslverr;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wt(input integer n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (!pready) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
    rd = prdQ;
    err = errQ;
  endtask
  task automatic pushCmd(input logic t, input logic c);
    @(posedge clk);
    tripKeyPin <= t;
    closeKeyPin <= c;
    nTrip = 0;
    nClose = 0;
    repeat (8) begin
      @(negedge clk);
      nTrip += tripCmd;
      nClose += closeCmd;
    end
    @(posedge clk);
    tripKeyPin <= 1'b0;
    closeKeyPin <= 1'b0;
  endtask
  task automatic tLocal;
    ops.keySeq(0);
    ops.keySeq(1);
    ops.keySeq(3);
    wt(1);
    chk("lamps", funcLamp, 9'h00b);
    chk("gnd", gndTripInhibit, 1'b1);
    chk("noRecl", {reclosingBlocked, oneTripLockout}, 2'b11);
    chk("first", curveSel, `FPC_CRV_FIRST);
    chk("inrushOff", useInrush, 1'b0);
    ops.keySeq(1);
    ops.keySeq(5);
    wt(1);
    chk("slow", curveSel, `FPC_CRV_SLOW);
  endtask
  task automatic tWindowAlt;
    ops.hold(9);
    wt(60);
    ops.hold(0);
    ops.keySeq(6);
    ops.hold(7);
    wt(1);
    chk("window", funcLamp, 9'h069);
    chk("prof1", profileSel, 2'h1);
    ops.keySeq(8);
    wt(1);
    chk("alt", funcLamp[8:6], 3'h4);
    chk("prof3", profileSel, 2'h3);
    apb(1'b1, `FPC_OFF_CLR, 32'h100);
    wt(1);
    chk("normal", profileSel, 2'h0);
  endtask
  task automatic tRemote;
    apb(1'b1, `FPC_OFF_CLR, 32'h009);
    ops.sup(1'b1, 4'h1);
    wt(1);
    chk("remote", funcLamp, 9'h022);
    chk("inrushOn", useInrush, 1'b1);
    ops.keySeq(2);
    apb(1'b1, `FPC_OFF_SET, 32'h001);
    apb(1'b1, `FPC_OFF_CLR, 32'h004);
    ops.sup(1'b0, 4'h2);
    ops.sup(1'b1, 4'h0);
    @(posedge clk);
    discSetPin <= 9'h040;
    wt(6);
    @(posedge clk);
    discSetPin <= 9'h000;
    wt(4);
    chk("locked", funcLamp, 9'h066);
    apb(1'b0, `FPC_OFF_STATUS, 32'h0);
    chk("status", rd[8:0], 9'h066);
    pushCmd(1'b1, 1'b0);
    chk("trip", nTrip, 1);
    pushCmd(1'b0, 1'b1);
    chk("close", nClose, 1);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmappedErr", err, 1'b1);
    chk("unmappedData", rd, 32'h0);
    ops.keySeq(2);
    @(posedge clk);
    discClrPin <= 9'h040;
    wt(6);
    @(posedge clk);
    discClrPin <= 9'h000;
    wt(4);
    chk("discClr", funcLamp, 9'h022);
    chk("discProf", profileSel, 2'h0);
  endtask
  task automatic tTag;
    ops.tag(1'b1);
    @(posedge clk);
    remoteCloseReq <= 1'b1;
    autoCloseReq <= 1'b1;
    pushCmd(1'b0, 1'b1);
    remoteCloseReq <= 1'b0;
    autoCloseReq <= 1'b0;
    chk("closeBlocked", nClose, 0);
    chk("tagCurve", curveSel, `FPC_CRV_TAG);
    ops.sup(1'b0, `FPC_SUP_TAG_IDX);
    wt(1);
    chk("tagHeld", tagLamp, 1'b1);
    ops.tag(1'b0);
    ops.sup(1'b1, `FPC_SUP_TAG_IDX);
    ops.tag(1'b1);
    ops.tag(1'b0);
    wt(1);
    chk("linkTag", tagLamp, 1'b1);
    ops.sup(1'b0, `FPC_SUP_TAG_IDX);
    wt(1);
    chk("tagOff", tagLamp, 1'b0);
    @(posedge clk);
    powerSave <= 1'b1;
    wt(3);
    chk("dark", funcLamp, 9'h000);
    @(posedge clk);
    powerSave <= 1'b0;
  endtask
  task automatic runBatt(input logic [15:0] loaded);
    apb(1'b1, `FPC_OFF_SET, 32'h010);
    repeat (100) if (!battLoadOn) @(posedge clk);
    battVoltMv <= loaded;
    repeat (100) if (battLoadOn) @(posedge clk);
    battVoltMv <= 16'h6590;
    wt(2);
    chk("battLamp", funcLamp[4], 1'b0);
  endtask
  task automatic tBatt;
    runBatt(16'h5bcc);
    chk("dropFault", battFaultLamp, 1'b1);
    apb(1'b0, `FPC_OFF_BATT, 32'h0);
    chk("battRegs", rd, 32'h5bcc6590);
    runBatt(16'h61a8);
    chk("passClears", battFaultLamp, 1'b0);
    @(posedge clk);
    battVoltMv <= 16'h5208;
    @(posedge clk);
    battVoltMv <= 16'h6590;
    wt(3);
    chk("lowFault", battFaultLamp, 1'b1);
  endtask
  task automatic endSim;
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    nMismatch++;
    endSim;
  end
  initial begin
    {rst_n, psel, penable, pwrite, tripKeyPin, closeKeyPin, powerSave, remoteCloseReq, autoCloseReq} = 9'h000;
    paddr = 12'h000;
    pwdata = 32'h0;
    discSetPin = 9'h000;
    discClrPin = 9'h000;
    battVoltMv = 16'h6590;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    wt(4);
    apb(1'b0, `FPC_OFF_STATUS, 32'h0);
    chk("statusRst", rd, 32'h0);
    tLocal;
    tWindowAlt;
    tRemote;
    tTag;
    tBatt;
    endSim;
  end
endmodule
`default_nettype wire
